// ===== rtl/aao_consts.vh
// Purpose: Shared constants for the add/AND datapath and its register slave
// Assumes: Included by bare name from the design files under rtl/
// Notes:   Definitions only
`ifndef AAO_CONSTS_VH
`define AAO_CONSTS_VH

// ==========================================================================
// Register word offsets (byte address bits [3:2])
`define AAO_IDX_INSTR        2'h0
`define AAO_IDX_ACC          2'h1
`define AAO_IDX_STATUS       2'h2
`define AAO_IDX_RESULT       2'h3

// ==========================================================================
// Status register fields
`define AAO_ST_CARRY         0
`define AAO_ST_NIBBLE        1
`define AAO_ST_ZERO          2
`define AAO_ST_BUSY          4
`define AAO_ST_UNSUP         8

// ==========================================================================
// Opcode fields and patterns (14-bit instruction word)
`define AAO_OP_TOP6          13:8
`define AAO_OP_TOP5          13:9
`define AAO_OP_DEST          7
`define AAO_OP_FILE          6:0
`define AAO_OP_LIT           7:0
`define AAO_PAT_ADD_LIT      5'h1F
`define AAO_PAT_AND_LIT      6'h39
`define AAO_PAT_ADD_FILE     6'h07
`define AAO_PAT_AND_FILE     6'h05

// ==========================================================================
// Operation classes
`define AAO_CL_NONE          3'h0
`define AAO_CL_ADD_LIT       3'h1
`define AAO_CL_AND_LIT       3'h2
`define AAO_CL_ADD_FILE      3'h3
`define AAO_CL_AND_FILE      3'h4

// ==========================================================================
// Bus responses and reset values
`define AAO_RESP_OKAY        2'h0
`define AAO_RESP_SLVERR      2'h2
`define AAO_RESP_DECERR      2'h3
`define AAO_RST_BYTE         8'h00
`define AAO_RST_WORD         32'h00000000

`endif

// ===== rtl/aao_alu_core.v
// Purpose: 8-bit add/AND core with carry, nibble carry and zero outputs
// Assumes: Purely combinational; the caller registers the results
// Notes:   Flags are computed for both operations; the caller picks which to keep
`timescale 1ns/100ps

module aao_alu_core #(
    parameter DATA_W = 8                        // Operand width
) (
    input  wire [DATA_W-1:0] acc_i,             // Working register operand
    input  wire [DATA_W-1:0] operand_i,         // Literal or file operand
    input  wire              do_add_i,          // High: add, low: AND
    output wire [DATA_W-1:0] result_o,          // Operation result
    output wire              carry_o,           // Carry out of the top bit
    output wire              nibble_carry_o,    // Carry out of bit 3
    output wire              zero_o             // Result is all zero
);

    wire [DATA_W:0] sum;
    wire [4:0]      low_sum;

    assign sum            = {1'b0, acc_i} + {1'b0, operand_i};
    assign low_sum        = {1'b0, acc_i[3:0]} + {1'b0, operand_i[3:0]};
    assign result_o       = do_add_i ? sum[DATA_W-1:0] : (acc_i & operand_i);
    assign carry_o        = sum[DATA_W];
    assign nibble_carry_o = low_sum[4];
    assign zero_o         = (result_o == {DATA_W{1'b0}});

endmodule // aao_alu_core

// ===== rtl/aao_datapath.v
// Purpose: Add/AND datapath for four core instructions, with AXI4-Lite registers
// Assumes: File register memory answers a read one cycle after file_re_o
// Notes:   Instructions arrive from the decoder port or from the INSTR register
//
// Notes on behaviour
// RULE_01 - Literal-AND decodes from 11 1001 and ANDs accumulator with immediate.
// RULE_02 - Literal-AND result goes to accumulator; only zero flag changes.
// RULE_03 - Add-register (00 0111) adds accumulator and file; updates carry, nibble carry, zero.
// RULE_04 - File instructions: destination bit 0 writes accumulator, 1 writes file.
// RULE_05 - AND-register (00 0101) ANDs accumulator with file; only zero flag changes.
// RULE_06 - Literal-add (11 111x) adds immediate into accumulator; updates all three flags.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "aao_consts.vh"

module aao_datapath #(
    parameter DATA_W = 8,                       // Datapath width
    parameter INSTR_W = 14,                     // Instruction word width
    parameter FADDR_W = 7                       // File address width
) (
    input  wire               ref_clk_i,        // Core clock
    input  wire               reset_i,          // Synchronous reset, active high
    // Decoder instruction port
    input  wire               instr_valid_i,    // Instruction offered
    input  wire [INSTR_W-1:0] instr_i,          // Instruction word
    output wire               instr_ready_o,    // Instruction can be taken this cycle
    output reg                done_o,           // One-cycle pulse when retired
    output reg  [DATA_W-1:0]  acc_o,            // Working register value
    output reg                carry_o,          // Carry flag
    output reg                nibble_carry_o,   // Nibble carry flag
    output reg                zero_o,           // Zero flag
    // File register memory
    output reg  [FADDR_W-1:0] file_addr_o,      // File address
    output reg                file_re_o,        // File read strobe
    input  wire [DATA_W-1:0]  file_rdata_i,     // File read data
    output reg                file_we_o,        // File write strobe
    output reg  [DATA_W-1:0]  file_wdata_o,     // File write data
    // AXI4-Lite slave
    input  wire [3:0]         s_axi_awaddr,     // Write address
    input  wire               s_axi_awvalid,    // Write address valid
    output wire               s_axi_awready,    // Write address ready
    input  wire [31:0]        s_axi_wdata,      // Write data
    input  wire [3:0]         s_axi_wstrb,      // Write strobes
    input  wire               s_axi_wvalid,     // Write data valid
    output wire               s_axi_wready,     // Write data ready
    output reg  [1:0]         s_axi_bresp,      // Write response
    output reg                s_axi_bvalid,     // Write response valid
    input  wire               s_axi_bready,     // Write response ready
    input  wire [3:0]         s_axi_araddr,     // Read address
    input  wire               s_axi_arvalid,    // Read address valid
    output wire               s_axi_arready,    // Read address ready
    output reg  [31:0]        s_axi_rdata,      // Read data
    output reg  [1:0]         s_axi_rresp,      // Read response
    output reg                s_axi_rvalid,     // Read data valid
    input  wire               s_axi_rready      // Read data ready
);

    // ======================================================================
    // Opcode classification, shared by issue and execute
    function [2:0] op_class;
        input [INSTR_W-1:0] op;
        begin
            // RULE_06 literal-add decode
            if (op[`AAO_OP_TOP5] == `AAO_PAT_ADD_LIT) begin
                op_class = `AAO_CL_ADD_LIT;
            // RULE_01 literal-AND decode
            end else if (op[`AAO_OP_TOP6] == `AAO_PAT_AND_LIT) begin
                op_class = `AAO_CL_AND_LIT;
            // RULE_03 add-register decode
            end else if (op[`AAO_OP_TOP6] == `AAO_PAT_ADD_FILE) begin
                op_class = `AAO_CL_ADD_FILE;
            // RULE_05 AND-register decode
            end else if (op[`AAO_OP_TOP6] == `AAO_PAT_AND_FILE) begin
                op_class = `AAO_CL_AND_FILE;
            end else begin
                op_class = `AAO_CL_NONE;
            end
        end
    endfunction

    // ======================================================================
    // State machine
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_READ = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;

    reg  [1:0]         state_q;
    reg  [1:0]         state_d;
    reg  [INSTR_W-1:0] op_q;
    reg  [DATA_W-1:0]  result_q;
    reg                unsup_q;

    // AXI holding registers
    reg                aw_held_q;
    reg  [1:0]         aw_idx_q;
    reg                w_held_q;
    reg  [31:0]        wdata_q;
    reg  [3:0]         wstrb_q;

    wire               busy;
    wire               wr_fire;
    wire               bus_instr;
    wire               port_take;
    wire               start;
    wire [INSTR_W-1:0] start_op;
    wire [2:0]         start_cls;
    wire [2:0]         exec_cls;
    wire [DATA_W-1:0]  operand;
    wire [DATA_W-1:0]  alu_res;
    wire               alu_c;
    wire               alu_nc;
    wire               alu_z;
    wire               exec_now;
    wire               file_op;
    wire               to_file;
    wire               is_add;

    assign busy      = (state_q != ST_IDLE);
    assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
    // Bus instruction needs both low byte lanes; otherwise it is refused
    assign bus_instr = wr_fire && !busy && (aw_idx_q == `AAO_IDX_INSTR)
                       && (wstrb_q[1:0] == 2'b11);
    // Bus issue has priority so a register write is never lost to the port
    assign port_take     = instr_valid_i && !busy && !bus_instr;
    assign instr_ready_o = !busy && !bus_instr;
    assign start         = bus_instr || port_take;
    assign start_op      = bus_instr ? wdata_q[INSTR_W-1:0] : instr_i;
    assign start_cls     = op_class(start_op);
    assign exec_cls      = op_class(op_q);
    assign exec_now      = (state_q == ST_EXEC);
    assign file_op       = (exec_cls == `AAO_CL_ADD_FILE) || (exec_cls == `AAO_CL_AND_FILE);
    assign is_add        = (exec_cls == `AAO_CL_ADD_LIT) || (exec_cls == `AAO_CL_ADD_FILE);
    // RULE_04 destination select
    assign to_file       = file_op && op_q[`AAO_OP_DEST];
    assign operand       = file_op ? file_rdata_i : op_q[`AAO_OP_LIT];

    aao_alu_core #(
        .DATA_W         (DATA_W)
    ) u_core (
        .acc_i          (acc_o),
        .operand_i      (operand),
        .do_add_i       (is_add),
        .result_o       (alu_res),
        .carry_o        (alu_c),
        .nibble_carry_o (alu_nc),
        .zero_o         (alu_z)
    );

    // ======================================================================
    // Sequencing
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    if ((start_cls == `AAO_CL_ADD_FILE) || (start_cls == `AAO_CL_AND_FILE)) begin
                        state_d = ST_READ;
                    end else if (start_cls != `AAO_CL_NONE) begin
                        state_d = ST_EXEC;
                    end
                end
            end
            // Memory data appears one cycle after the read strobe
            ST_READ: begin
                state_d = ST_EXEC;
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q     <= ST_IDLE;
            op_q        <= {INSTR_W{1'b0}};
            file_addr_o <= {FADDR_W{1'b0}};
            file_re_o   <= 1'b0;
        end else begin
            state_q   <= state_d;
            file_re_o <= 1'b0;
            if (start) begin
                op_q        <= start_op;
                file_addr_o <= start_op[`AAO_OP_FILE];
                file_re_o   <= (state_d == ST_READ);
            end
        end
    end

    // ======================================================================
    // Accumulator, flags and file write-back
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            acc_o          <= `AAO_RST_BYTE;
            carry_o        <= 1'b0;
            nibble_carry_o <= 1'b0;
            zero_o         <= 1'b0;
            result_q       <= `AAO_RST_BYTE;
            file_we_o      <= 1'b0;
            file_wdata_o   <= `AAO_RST_BYTE;
            done_o         <= 1'b0;
            unsup_q        <= 1'b0;
        end else begin
            file_we_o <= 1'b0;
            done_o    <= exec_now;
            if (exec_now) begin
                result_q <= alu_res;
                // RULE_02 RULE_05 zero always tracks
                zero_o   <= alu_z;
                // RULE_03 RULE_06 arithmetic flags
                if (is_add) begin
                    carry_o        <= alu_c;
                    nibble_carry_o <= alu_nc;
                end
                // RULE_04 write-back target
                if (to_file) begin
                    file_we_o    <= 1'b1;
                    file_wdata_o <= alu_res;
                end else begin
                    // RULE_01 RULE_02 accumulator result
                    acc_o <= alu_res;
                end
            end else if (wr_fire && !busy) begin
                // Software may preload accumulator and flags while idle
                if (aw_idx_q == `AAO_IDX_ACC && wstrb_q[0]) begin
                    acc_o <= wdata_q[DATA_W-1:0];
                end
                if (aw_idx_q == `AAO_IDX_STATUS && wstrb_q[0]) begin
                    carry_o        <= wdata_q[`AAO_ST_CARRY];
                    nibble_carry_o <= wdata_q[`AAO_ST_NIBBLE];
                    zero_o         <= wdata_q[`AAO_ST_ZERO];
                end
            end
            // Set wins over a write-one clear in the same cycle
            if (start && (start_cls == `AAO_CL_NONE)) begin
                unsup_q <= 1'b1;
            end else if (wr_fire && !busy && (aw_idx_q == `AAO_IDX_STATUS) && wstrb_q[1]
                         && wdata_q[`AAO_ST_UNSUP]) begin
                unsup_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // AXI4-Lite write channel
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            aw_held_q    <= 1'b0;
            aw_idx_q     <= 2'b00;
            w_held_q     <= 1'b0;
            wdata_q      <= `AAO_RST_WORD;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AAO_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[3:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Result register is read-only; writes while busy are refused
                if (aw_idx_q == `AAO_IDX_RESULT) begin
                    s_axi_bresp <= `AAO_RESP_DECERR;
                end else if (busy || (aw_idx_q == `AAO_IDX_INSTR && !bus_instr)) begin
                    s_axi_bresp <= `AAO_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `AAO_RESP_OKAY;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `AAO_RST_WORD;
            s_axi_rresp  <= `AAO_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `AAO_RESP_OKAY;
                s_axi_rdata  <= `AAO_RST_WORD;
                case (s_axi_araddr[3:2])
                    `AAO_IDX_INSTR: begin
                        s_axi_rdata[INSTR_W-1:0] <= op_q;
                    end
                    `AAO_IDX_ACC: begin
                        s_axi_rdata[DATA_W-1:0] <= acc_o;
                    end
                    `AAO_IDX_STATUS: begin
                        s_axi_rdata[`AAO_ST_CARRY]  <= carry_o;
                        s_axi_rdata[`AAO_ST_NIBBLE] <= nibble_carry_o;
                        s_axi_rdata[`AAO_ST_ZERO]   <= zero_o;
                        s_axi_rdata[`AAO_ST_BUSY]   <= busy;
                        s_axi_rdata[`AAO_ST_UNSUP]  <= unsup_q;
                    end
                    `AAO_IDX_RESULT: begin
                        s_axi_rdata[DATA_W-1:0] <= result_q;
                    end
                    default: begin
                        s_axi_rresp <= `AAO_RESP_DECERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // aao_datapath

// ===== tb/aao_datapath_asserts.sv
// Purpose: Port checks for the add/AND datapath
// Assumes: File data arrives the cycle after the read strobe
// Notes:   Only decoder-port instructions are decoded; the zero check covers every retirement
`timescale 1ns/100ps

module aao_datapath_asserts (
    input wire logic        ref_clk_i,      // Clock
    input wire logic        reset_i,        // Reset
    input wire logic        instr_valid_i,  // Offered
    input wire logic [13:0] instr_i,        // Word
    input wire logic        instr_ready_o,  // Ready
    input wire logic        done_o,         // Retired
    input wire logic [7:0]  acc_o,          // Accumulator
    input wire logic        carry_o,        // Carry
    input wire logic        nibble_carry_o, // Nibble carry
    input wire logic        zero_o,         // Zero
    input wire logic        file_re_o,      // File read
    input wire logic [7:0]  file_rdata_i,   // File data in
    input wire logic        file_we_o,      // File write
    input wire logic [7:0]  file_wdata_o    // File data out
);
    // ======================================================================
    // Decode of taken instructions
    wire       take    = instr_valid_i && instr_ready_o;
    wire [5:0] top     = instr_i[13:8];
    wire       and_lit = take && top == 6'h39;
    wire       add_lit = take && top[5:1] == 5'h1F;
    wire       add_f   = take && top == 6'h07;
    wire       and_f   = take && top == 6'h05;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // Literal ops retire two edges after the take, file ops three
    sequence s_lit_exec;
        !done_o ##1 done_o;
    endsequence
    sequence s_file_exec;
        file_re_o && !done_o ##1 !file_re_o && !done_o ##1 done_o;
    endsequence

    // ======================================================================
    // Checks
    a_and_lit_value: assert property (and_lit |=> s_lit_exec ##0
        acc_o == ($past(acc_o, 2) & $past(instr_i[7:0], 2))) else $error("literal AND wrong");
    a_and_lit_flags: assert property (and_lit |=> s_lit_exec ##0
        (carry_o == $past(carry_o, 2) && nibble_carry_o == $past(nibble_carry_o, 2)))
        else $error("literal AND touched carries");
    a_add_lit_sum: assert property (add_lit |=> s_lit_exec ##0
        {carry_o, acc_o} == {1'b0, $past(acc_o, 2)} + {1'b0, $past(instr_i[7:0], 2)})
        else $error("literal add wrong");
    a_add_lit_nibble: assert property (add_lit |=> s_lit_exec ##0
        nibble_carry_o == ({1'b0, $past(acc_o[3:0], 2)} + {1'b0, $past(instr_i[3:0], 2)} > 5'h0F))
        else $error("literal add nibble carry wrong");
    a_zero_result: assert property (done_o |->
        zero_o == ((file_we_o ? file_wdata_o : acc_o) == 8'h00)) else $error("zero flag wrong");
    a_add_file_acc: assert property (add_f && !instr_i[7] |=> s_file_exec ##0
        (!file_we_o && {carry_o, acc_o} == {1'b0, $past(acc_o, 3)} + {1'b0, $past(file_rdata_i)}))
        else $error("file add to accumulator wrong");
    a_add_file_wb: assert property (add_f && instr_i[7] |=> s_file_exec ##0
        (file_we_o && acc_o == $past(acc_o, 3) &&
        {carry_o, file_wdata_o} == {1'b0, $past(acc_o, 3)} + {1'b0, $past(file_rdata_i)}))
        else $error("file add write-back wrong");
    a_and_file_op: assert property (and_f |=> s_file_exec ##0
        (file_we_o == $past(instr_i[7], 3) && carry_o == $past(carry_o, 3) &&
        ($past(instr_i[7], 3) ? file_wdata_o : acc_o) == ($past(acc_o, 3) & $past(file_rdata_i))))
        else $error("file AND wrong");
endmodule // aao_datapath_asserts

bind aao_datapath aao_datapath_asserts u_chk (.ref_clk_i, .reset_i, .instr_valid_i, .instr_i,
    .instr_ready_o, .done_o, .acc_o, .carry_o, .nibble_carry_o, .zero_o, .file_re_o,
    .file_rdata_i, .file_we_o, .file_wdata_o);

// ===== tb/aao_file_mem.sv
// Purpose: File register memory beside the datapath
// Assumes: Synchronous read with one cycle of latency
// Notes:   Read data is valid only in the cycle after a read
`timescale 1ns/100ps

module aao_file_mem (
    input  wire logic       ref_clk_i,  // Clock
    input  wire logic [6:0] addr_i,     // Address
    input  wire logic       re_i,       // Read strobe
    input  wire logic       we_i,       // Write strobe
    input  wire logic [7:0] wdata_i,    // Write data
    output logic      [7:0] rdata_o     // Read data
);
    logic [7:0] mem_q [0:127];

    initial rdata_o = 8'hA5;

    // Stale data toggles so a sample one cycle late never matches by luck
    always @(posedge ref_clk_i) begin
        rdata_o <= re_i ? mem_q[addr_i] : ~rdata_o;
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end
endmodule // aao_file_mem

// ===== tb/tb_add_and_alu_ops.sv
// Purpose: Self-checking bench for the add/AND datapath
// Assumes: Behavioural file memory on the far side
// Notes:   Each run case preloads accumulator, flags and file, then retires one op
`timescale 1ns/100ps

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_add_and_alu_ops;
    logic        ref_clk_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic        instr_ready_o, done_o, carry_o, nibble_carry_o, zero_o;
    logic [7:0]  acc_o, file_rdata_i, file_wdata_o;
    logic [6:0]  file_addr_o;
    logic        file_re_o, file_we_o;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    integer      errors = 0, tests_run = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    aao_datapath dut (.ref_clk_i, .reset_i, .instr_valid_i, .instr_i, .instr_ready_o, .done_o,
        .acc_o, .carry_o, .nibble_carry_o, .zero_o, .file_addr_o, .file_re_o, .file_rdata_i,
        .file_we_o, .file_wdata_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    aao_file_mem u_mem (.ref_clk_i, .addr_i(file_addr_o), .re_i(file_re_o), .we_i(file_we_o),
        .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));

    // ======================================================================
    // Tasks
    task wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A wait that used up its bound counts as a mismatch and ends the run
    task guard(input logic pending);
        if (pending) begin
            errors++;
            wrap_up;
        end
    endtask

    task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
        integer n;
        logic   aw, w, b;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            {aw, w, b} = 3'h7;
            for (n = 0; b && n < 30; n++) begin
                @(posedge ref_clk_i);
                if (aw && s_axi_awready) begin
                    aw = 1'b0;
                    s_axi_awvalid <= 1'b0;
                end
                if (w && s_axi_wready) begin
                    w = 1'b0;
                    s_axi_wvalid <= 1'b0;
                end
                if (s_axi_bvalid) begin
                    b = 1'b0;
                    `CHK(s_axi_bresp, er)
                end
            end
            s_axi_bready <= 1'b0;
            @(posedge ref_clk_i);
            guard(b);
        end
    endtask

    task axi_rd(input [3:0] a, input [31:0] ed);
        integer n;
        logic   ar, r;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            {ar, r} = 2'h3;
            for (n = 0; r && n < 30; n++) begin
                @(posedge ref_clk_i);
                if (ar && s_axi_arready) begin
                    ar = 1'b0;
                    s_axi_arvalid <= 1'b0;
                end
                if (s_axi_rvalid) begin
                    r = 1'b0;
                    `CHK({s_axi_rresp, s_axi_rdata}, {2'h0, ed})
                end
            end
            s_axi_rready <= 1'b0;
            @(posedge ref_clk_i);
            guard(r);
        end
    endtask

    task issue(input [13:0] ins);
        integer n;
        logic   t, d;
        begin
            instr_i <= ins;
            instr_valid_i <= 1'b1;
            {t, d} = 2'h3;
            for (n = 0; d && n < 30; n++) begin
                @(posedge ref_clk_i);
                if (t && instr_ready_o) begin
                    t = 1'b0;
                    instr_valid_i <= 1'b0;
                end else if (!t && done_o === 1'b1) begin
                    d = 1'b0;
                end
            end
            guard(d);
        end
    endtask

    // Flags are packed as zero, nibble carry, carry
    task run(input [13:0] ins, input [7:0] a, f, input [2:0] pre, input [7:0] ea, ef,
             input [2:0] es);
        begin
            u_mem.mem_q[ins[6:0]] = f;
            axi_wr(4'h4, {24'h0, a}, 2'h0);
            axi_wr(4'h8, {29'h0, pre}, 2'h0);
            issue(ins);
            `CHK(acc_o, ea)
            `CHK({zero_o, nibble_carry_o, carry_o}, es)
            axi_rd(4'h8, {29'h0, es});
            axi_rd(4'hC, {24'h0, (ins[13] | ~ins[7]) ? ea : ef});
            // Write-back lands on the done edge; compare once it has settled
            `CHK(u_mem.mem_q[ins[6:0]], ef)
        end
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        axi_rd(4'h0, 32'h0);
        axi_rd(4'h4, 32'h0);
        axi_rd(4'h8, 32'h0);
        axi_rd(4'hC, 32'h0);
        run(14'h3E15, 8'h10, 8'h11, 3'h7, 8'h25, 8'h11, 3'h0);
        run(14'h3F08, 8'hF8, 8'h22, 3'h0, 8'h00, 8'h22, 3'h7);
        run(14'h39A3, 8'h5F, 8'h33, 3'h3, 8'h03, 8'h33, 3'h3);
        run(14'h3900, 8'hFF, 8'h44, 3'h0, 8'h00, 8'h44, 3'h4);
        run(14'h0704, 8'h17, 8'hC2, 3'h7, 8'hD9, 8'hC2, 3'h0);
        run(14'h07FF, 8'h99, 8'h67, 3'h0, 8'h99, 8'h00, 3'h7);
        run(14'h0584, 8'h17, 8'hC2, 3'h3, 8'h17, 8'h02, 3'h3);
        run(14'h0500, 8'h0F, 8'hF0, 3'h0, 8'h00, 8'hF0, 3'h4);
        // Two successive issues on the decoder port, the second offered after done_o of the first
        issue(14'h3E01);
        issue(14'h3EFF);
        `CHK({zero_o, nibble_carry_o, carry_o, acc_o}, 11'h700)
        // Bus-issued instruction, then a refused write to the result word
        axi_wr(4'h0, 32'h00003E05, 2'h0);
        `CHK(acc_o, 8'h05)
        axi_rd(4'h0, 32'h00003E05);
        axi_wr(4'hC, 32'h000000FF, 2'h3);
        axi_rd(4'hC, 32'h00000005);
        // Unknown opcode from the bus sets the sticky flag; write one clears it
        axi_wr(4'h0, 32'h00000000, 2'h0);
        axi_rd(4'h8, 32'h00000100);
        axi_wr(4'h8, 32'h00000100, 2'h0);
        axi_rd(4'h8, 32'h00000000);
        wrap_up;
    end
endmodule // tb_add_and_alu_ops
